//--- src/sfce_defines.vh
`ifndef SFCE_DEFINES_VH
`define SFCE_DEFINES_VH

// Core clock rate in MHz, used to turn times into cycle counts.
`define SFCE_CLK_MHZ       50

// Self-timed operation maxima in microseconds (plain defaults).
`define SFCE_T_EP_US       20000
`define SFCE_T_P_US        14000
`define SFCE_T_PE_US       8000
`define SFCE_T_BE_US       12000
`define SFCE_T_XFR_US      300

// Page and buffer geometry.
`define SFCE_PAGE_BYTES    10'h108
`define SFCE_LAST_BYTE     9'h107
`define SFCE_ERASED        8'hFF
`define SFCE_BLK_LAST      3'h7

// Rising-edge counts at which a framing field completes (count before edge).
`define SFCE_BIT_OPCODE    7'h07
`define SFCE_BIT_ADDR      7'h1F
`define SFCE_BIT_BUFRD     7'h27
`define SFCE_BIT_PGRD      7'h3F
`define SFCE_CNT_SAT       7'h40

// Status byte fixed fields; the density code value is arbitrary.
`define SFCE_DENSITY       3'h5
`define SFCE_STAT_RSVD     3'h0

// Opcodes.
`define SFCE_OP_PGRD_A     8'h52
`define SFCE_OP_PGRD_B     8'hD2
`define SFCE_OP_ARRD_A     8'h68
`define SFCE_OP_ARRD_B     8'hE8
`define SFCE_OP_B1RD_A     8'h54
`define SFCE_OP_B1RD_B     8'hD4
`define SFCE_OP_B2RD_A     8'h56
`define SFCE_OP_B2RD_B     8'hD6
`define SFCE_OP_STAT_A     8'h57
`define SFCE_OP_STAT_B     8'hD7
`define SFCE_OP_B1WR       8'h84
`define SFCE_OP_B2WR       8'h87
`define SFCE_OP_B1PE       8'h83
`define SFCE_OP_B2PE       8'h86
`define SFCE_OP_B1PN       8'h88
`define SFCE_OP_B2PN       8'h89
`define SFCE_OP_PERASE     8'h81
`define SFCE_OP_BERASE     8'h50
`define SFCE_OP_B1PTB      8'h82
`define SFCE_OP_B2PTB      8'h85
`define SFCE_OP_B1XFR      8'h53
`define SFCE_OP_B2XFR      8'h55
`define SFCE_OP_B1CMP      8'h60
`define SFCE_OP_B2CMP      8'h61
`define SFCE_OP_B1RW       8'h58
`define SFCE_OP_B2RW       8'h59

// Command classes.
`define SFCE_C_NONE        4'h0
`define SFCE_C_PGRD        4'h1
`define SFCE_C_ARRD        4'h2
`define SFCE_C_BFRD        4'h3
`define SFCE_C_STAT        4'h4
`define SFCE_C_BFWR        4'h5
`define SFCE_C_PROGE       4'h6
`define SFCE_C_PROG        4'h7
`define SFCE_C_PERASE      4'h8
`define SFCE_C_BERASE      4'h9
`define SFCE_C_PTB         4'hA
`define SFCE_C_XFER        4'hB
`define SFCE_C_COMP        4'hC
`define SFCE_C_REWR        4'hD

`endif

//--- src/sfce_busy_timer.v
`timescale 1ns/100ps

// Down-counter that holds busy for a loaded number of core cycles.
module sfce_busy_timer #(
	parameter CW = 32
) (
	input  wire          clk,
	input  wire          rst_n,
	input  wire          start,
	input  wire [CW-1:0] load,
	output wire          busy
);

reg [CW-1:0] cnt_r;

// A fresh start reloads even a running count; the engine never does so.
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		cnt_r <= {CW{1'b0}};
	end else if (start) begin
		cnt_r <= load;
	end else if (cnt_r != {CW{1'b0}}) begin
		cnt_r <= cnt_r - {{(CW-1){1'b0}}, 1'b1};
	end
end

assign busy = (cnt_r != {CW{1'b0}});

endmodule // sfce_busy_timer

//--- src/sfce_flash_engine.v
`timescale 1ns/100ps
`include "sfce_defines.vh"
module sfce_flash_engine #(
	parameter PAGE_W            = 11,
	parameter ERASE_PROGRAM_CYC = `SFCE_T_EP_US * `SFCE_CLK_MHZ,
	parameter PROGRAM_CYC       = `SFCE_T_P_US * `SFCE_CLK_MHZ,
	parameter PAGE_ERASE_CYC    = `SFCE_T_PE_US * `SFCE_CLK_MHZ,
	parameter BLOCK_ERASE_CYC   = `SFCE_T_BE_US * `SFCE_CLK_MHZ,
	parameter XFER_CYC          = `SFCE_T_XFR_US * `SFCE_CLK_MHZ
) (
	input  wire core_clk,
	input  wire reset_n,
	input  wire serial_clock,
	input  wire chip_select_n,
	input  wire serial_in,
	output wire serial_out,
	output wire serial_out_oe,
	output wire ready_busy
);

localparam MEM_N  = (1 << PAGE_W) * 264;
localparam MEM_AW = PAGE_W + 9;
localparam BUF_N  = 2 * 264;
localparam ST_IDLE = 1'b0;
localparam ST_WALK = 1'b1;

////////////////////////////////////////////////////////////////////////////
// Decoding helpers.

// Maps an opcode onto the command class that drives all sequencing.
function [3:0] op_class;
	input [7:0] op;
	begin
		case (op)
		`SFCE_OP_PGRD_A, `SFCE_OP_PGRD_B: op_class = `SFCE_C_PGRD;
		`SFCE_OP_ARRD_A, `SFCE_OP_ARRD_B: op_class = `SFCE_C_ARRD;
		`SFCE_OP_B1RD_A, `SFCE_OP_B1RD_B,
		`SFCE_OP_B2RD_A, `SFCE_OP_B2RD_B: op_class = `SFCE_C_BFRD;
		`SFCE_OP_STAT_A, `SFCE_OP_STAT_B: op_class = `SFCE_C_STAT;
		`SFCE_OP_B1WR, `SFCE_OP_B2WR:     op_class = `SFCE_C_BFWR;
		`SFCE_OP_B1PE, `SFCE_OP_B2PE:     op_class = `SFCE_C_PROGE;
		`SFCE_OP_B1PN, `SFCE_OP_B2PN:     op_class = `SFCE_C_PROG;
		`SFCE_OP_PERASE:                  op_class = `SFCE_C_PERASE;
		`SFCE_OP_BERASE:                  op_class = `SFCE_C_BERASE;
		`SFCE_OP_B1PTB, `SFCE_OP_B2PTB:   op_class = `SFCE_C_PTB;
		`SFCE_OP_B1XFR, `SFCE_OP_B2XFR:   op_class = `SFCE_C_XFER;
		`SFCE_OP_B1CMP, `SFCE_OP_B2CMP:   op_class = `SFCE_C_COMP;
		`SFCE_OP_B1RW, `SFCE_OP_B2RW:     op_class = `SFCE_C_REWR;
		default:                          op_class = `SFCE_C_NONE;
		endcase
	end
endfunction

// Buffer two is chosen by the second opcode of each pair.
function op_buf;
	input [7:0] op;
	begin
		case (op)
		`SFCE_OP_B2RD_A, `SFCE_OP_B2RD_B, `SFCE_OP_B2WR,
		`SFCE_OP_B2PE, `SFCE_OP_B2PN, `SFCE_OP_B2PTB,
		`SFCE_OP_B2XFR, `SFCE_OP_B2CMP, `SFCE_OP_B2RW: op_buf = 1'b1;
		default: op_buf = 1'b0;
		endcase
	end
endfunction

// True for commands that run a self-timed array operation.
function is_array_op;
	input [3:0] c;
	begin
		case (c)
		`SFCE_C_PROGE, `SFCE_C_PROG, `SFCE_C_PERASE, `SFCE_C_BERASE,
		`SFCE_C_PTB, `SFCE_C_XFER, `SFCE_C_COMP,
		`SFCE_C_REWR: is_array_op = 1'b1;
		default: is_array_op = 1'b0;
		endcase
	end
endfunction

function [MEM_AW-1:0] mem_idx;
	input [PAGE_W-1:0] pg;
	input [8:0]        by;
	begin
		mem_idx = pg * `SFCE_PAGE_BYTES + by;
	end
endfunction

function [9:0] buf_idx;
	input       sel;
	input [8:0] by;
	begin
		buf_idx = (sel ? `SFCE_PAGE_BYTES : 10'h000) + by;
	end
endfunction

// Out-of-range start addresses above 263 also fall back to zero.
function [8:0] next_byte;
	input [8:0] by;
	begin
		next_byte = (by >= `SFCE_LAST_BYTE) ? 9'h000 : by + 9'h001;
	end
endfunction

////////////////////////////////////////////////////////////////////////////
// Reset release and pin synchronisers.

reg rst_m_r;
reg rst_s_r;
reg sck_m_r, sck_s_r, sck_d_r;
reg cs_m_r, cs_s_r, cs_d_r;
reg si_m_r, si_s_r;
wire rst_n = rst_s_r;

// Reset asserts at once but leaves on a clock edge, two flops deep.
always @(posedge core_clk or negedge reset_n) begin
	if (!reset_n) begin
		rst_m_r <= 1'b0;
		rst_s_r <= 1'b0;
	end else begin
		rst_m_r <= 1'b1;
		rst_s_r <= rst_m_r;
	end
end

// Pins cross in through two flops; the third sck/cs flop finds edges.
always @(posedge core_clk or negedge rst_n) begin
	if (!rst_n) begin
		sck_m_r <= 1'b0;
		sck_s_r <= 1'b0;
		sck_d_r <= 1'b0;
		cs_m_r  <= 1'b1;
		cs_s_r  <= 1'b1;
		cs_d_r  <= 1'b1;
		si_m_r  <= 1'b0;
		si_s_r  <= 1'b0;
	end else begin
		sck_m_r <= serial_clock;
		sck_s_r <= sck_m_r;
		sck_d_r <= sck_s_r;
		cs_m_r  <= chip_select_n;
		cs_s_r  <= cs_m_r;
		cs_d_r  <= cs_s_r;
		si_m_r  <= serial_in;
		si_s_r  <= si_m_r;
	end
end

wire sck_rise = sck_s_r & ~sck_d_r;
wire sck_fall = ~sck_s_r & sck_d_r;
wire cs_fall  = ~cs_s_r & cs_d_r;
wire cs_rise  = cs_s_r & ~cs_d_r;
wire selected = ~cs_s_r & ~cs_d_r;

////////////////////////////////////////////////////////////////////////////
// Storage and status.

reg [7:0] mem [0:MEM_N-1];
reg [7:0] bufm [0:BUF_N-1];

reg [31:0]       in_sh_r;
reg [6:0]        cnt_r;
reg [3:0]        cls_r;
reg              bsel_r;
reg [PAGE_W-1:0] page_r;
reg [8:0]        ptr_r;
reg [2:0]        wbit_r;
reg              rd_act_r;
reg [2:0]        obit_r;
reg [7:0]        osh_r;
reg              so_r;
reg              so_oe_r;
reg              stat_b7_r;
reg              ready_r;
reg              comp_r;

wire [31:0] sh_nxt = {in_sh_r[30:0], si_s_r};
wire [7:0]  status_byte = {ready_r, comp_r, `SFCE_DENSITY,
	`SFCE_STAT_RSVD};
wire wr_phase = ((cls_r == `SFCE_C_BFWR) || (cls_r == `SFCE_C_PTB)) &&
	(cnt_r > `SFCE_BIT_ADDR);
wire ser_wr = selected & sck_rise & wr_phase & (wbit_r == 3'h7);
wire [7:0] ser_byte = sh_nxt[7:0];
wire is_stat = (cls_r == `SFCE_C_STAT);

reg [7:0] src_byte;

// Picks the byte to send next: live status, a buffer or the array.
always @* begin
	case (cls_r)
	`SFCE_C_STAT: src_byte = status_byte;
	`SFCE_C_BFRD: src_byte = bufm[buf_idx(bsel_r, ptr_r)];
	default:      src_byte = mem[mem_idx(page_r, ptr_r)];
	endcase
end

////////////////////////////////////////////////////////////////////////////
// Serial front end: command capture, write data and read data.

// One process owns the pointer, since reads and writes both move it.
always @(posedge core_clk or negedge rst_n) begin
	if (!rst_n) begin
		in_sh_r   <= 32'h00000000;
		cnt_r     <= 7'h00;
		cls_r     <= `SFCE_C_NONE;
		bsel_r    <= 1'b0;
		page_r    <= {PAGE_W{1'b0}};
		ptr_r     <= 9'h000;
		wbit_r    <= 3'h0;
		rd_act_r  <= 1'b0;
		obit_r    <= 3'h0;
		osh_r     <= 8'h00;
		so_r      <= 1'b0;
		so_oe_r   <= 1'b0;
		stat_b7_r <= 1'b0;
	end else if (cs_fall) begin
		cnt_r     <= 7'h00;
		cls_r     <= `SFCE_C_NONE;
		wbit_r    <= 3'h0;
		rd_act_r  <= 1'b0;
		obit_r    <= 3'h0;
		stat_b7_r <= 1'b0;
	end else if (cs_rise) begin
		rd_act_r  <= 1'b0;
		so_oe_r   <= 1'b0;
		stat_b7_r <= 1'b0;
	end else if (selected) begin
		if (sck_rise) begin
			in_sh_r <= sh_nxt;
			if (cnt_r != `SFCE_CNT_SAT)
				cnt_r <= cnt_r + 7'h01;
			if (cnt_r == `SFCE_BIT_OPCODE) begin
				cls_r  <= op_class(sh_nxt[7:0]);
				bsel_r <= op_buf(sh_nxt[7:0]);
				if (op_class(sh_nxt[7:0]) == `SFCE_C_STAT) begin
					rd_act_r <= 1'b1;
					so_oe_r  <= 1'b1;
				end
			end
			if (cnt_r == `SFCE_BIT_ADDR) begin
				page_r <= sh_nxt[9 +: PAGE_W];
				ptr_r  <= sh_nxt[8:0];
			end
			if (cnt_r == `SFCE_BIT_BUFRD && cls_r == `SFCE_C_BFRD) begin
				rd_act_r <= 1'b1;
				so_oe_r  <= 1'b1;
			end
			if (cnt_r == `SFCE_BIT_PGRD && (cls_r == `SFCE_C_PGRD ||
				cls_r == `SFCE_C_ARRD)) begin
				rd_act_r <= 1'b1;
				so_oe_r  <= 1'b1;
			end
			if (wr_phase) begin
				wbit_r <= wbit_r + 3'h1;
				if (wbit_r == 3'h7)
					ptr_r <= next_byte(ptr_r);
			end
		end
		if (sck_fall && rd_act_r) begin
			if (obit_r == 3'h0) begin
				so_r      <= src_byte[7];
				osh_r     <= {src_byte[6:0], 1'b0};
				obit_r    <= 3'h7;
				stat_b7_r <= is_stat;
				if (!is_stat)
					ptr_r <= next_byte(ptr_r);
				if (cls_r == `SFCE_C_ARRD &&
					next_byte(ptr_r) == 9'h000)
					page_r <= page_r + {{(PAGE_W-1){1'b0}}, 1'b1};
			end else begin
				so_r      <= osh_r[7];
				osh_r     <= {osh_r[6:0], 1'b0};
				obit_r    <= obit_r - 3'h1;
				stat_b7_r <= 1'b0;
			end
		end else if (stat_b7_r && is_stat) begin
			so_r <= ready_r;
		end
	end
end

assign serial_out    = so_r;
assign serial_out_oe = so_oe_r;
assign ready_busy    = ready_r;

////////////////////////////////////////////////////////////////////////////
// Self-timed array engine.

reg              eng_st_r;
reg [3:0]        e_cls_r;
reg              e_sel_r;
reg [PAGE_W-1:0] e_page_r;
reg [2:0]        e_pg_r;
reg [8:0]        e_by_r;
reg              diff_r;
reg [31:0]       dur;
wire             tmr_busy;

// Busy commands are refused, so the host ordering is also enforced here.
wire launch = cs_rise & (cnt_r > `SFCE_BIT_ADDR) & is_array_op(cls_r) &
	ready_r;
wire walking = (eng_st_r == ST_WALK);
wire [PAGE_W-1:0] e_cur_pg = {e_page_r[PAGE_W-1:3],
	e_page_r[2:0] | e_pg_r};
wire [MEM_AW-1:0] e_midx = mem_idx(e_cur_pg, e_by_r);
wire [9:0] e_bidx = buf_idx(e_sel_r, e_by_r);
wire [7:0] mem_q = mem[e_midx];
wire [7:0] buf_q = bufm[e_bidx];
wire e_last = (e_by_r == `SFCE_LAST_BYTE) &&
	(e_cls_r != `SFCE_C_BERASE || e_pg_r == `SFCE_BLK_LAST);

// Each class loads its maximum duration; erase-program, PTB and rewrite share one, compare uses the transfer time.
always @* begin
	case (cls_r)
	`SFCE_C_PROGE, `SFCE_C_PTB,
	`SFCE_C_REWR:   dur = ERASE_PROGRAM_CYC;
	`SFCE_C_PROG:   dur = PROGRAM_CYC;
	`SFCE_C_PERASE: dur = PAGE_ERASE_CYC;
	`SFCE_C_BERASE: dur = BLOCK_ERASE_CYC;
	default:        dur = XFER_CYC;
	endcase
end

// Walks one byte per core cycle, then waits out the timer.
always @(posedge core_clk or negedge rst_n) begin
	if (!rst_n) begin
		eng_st_r <= ST_IDLE;
		e_cls_r  <= `SFCE_C_NONE;
		e_sel_r  <= 1'b0;
		e_page_r <= {PAGE_W{1'b0}};
		e_pg_r   <= 3'h0;
		e_by_r   <= 9'h000;
		diff_r   <= 1'b0;
		comp_r   <= 1'b0;
		ready_r  <= 1'b0;
	end else begin
		ready_r <= ~(launch | walking | tmr_busy);
		case (eng_st_r)
		ST_IDLE: begin
			if (launch) begin
				eng_st_r <= ST_WALK;
				e_cls_r  <= cls_r;
				e_sel_r  <= bsel_r;
				e_page_r <= (cls_r == `SFCE_C_BERASE) ?
					{page_r[PAGE_W-1:3], 3'h0} : page_r;
				e_pg_r   <= 3'h0;
				e_by_r   <= 9'h000;
				diff_r   <= 1'b0;
			end
		end
		ST_WALK: begin
			if (mem_q != buf_q)
				diff_r <= 1'b1;
			if (e_last) begin
				eng_st_r <= ST_IDLE;
				if (e_cls_r == `SFCE_C_COMP)
					comp_r <= diff_r | (mem_q != buf_q);
			end else if (e_by_r == `SFCE_LAST_BYTE) begin
				e_by_r <= 9'h000;
				e_pg_r <= e_pg_r + 3'h1;
			end else begin
				e_by_r <= e_by_r + 9'h001;
			end
		end
		default: eng_st_r <= ST_IDLE;
		endcase
	end
end

// Memory writes; serial buffer loads may run beside an array operation.
always @(posedge core_clk) begin
	if (ser_wr)
		bufm[buf_idx(bsel_r, ptr_r)] <= ser_byte;
	if (walking) begin
		case (e_cls_r)
		`SFCE_C_XFER, `SFCE_C_REWR: bufm[e_bidx] <= mem_q;
		`SFCE_C_PROGE, `SFCE_C_PTB: mem[e_midx] <= buf_q;
		`SFCE_C_PROG:   mem[e_midx] <= mem_q & buf_q;
		`SFCE_C_PERASE: mem[e_midx] <= `SFCE_ERASED;
		`SFCE_C_BERASE: mem[e_midx] <= `SFCE_ERASED;
		default: ;
		endcase
	end
end

sfce_busy_timer #(
	.CW (32)
) u_timer (
	.clk   (core_clk),
	.rst_n (rst_n),
	.start (launch),
	.load  (dur),
	.busy  (tmr_busy)
);

endmodule // sfce_flash_engine

//--- verif/sfce_flash_engine_sva.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// Pin checks; every self-timed duration is assumed set to BUSY_CYC.
module sfce_flash_engine_sva #(
	parameter int BUSY_CYC = 3000
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic serial_clock,
	input wire logic chip_select_n,
	input wire logic serial_in,
	input wire logic serial_out,
	input wire logic serial_out_oe,
	input wire logic ready_busy
);
	logic [31:0] lo_cnt;
	logic        armed;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	// Busy length counter; the rise just after reset is not an operation.
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			lo_cnt <= 32'h0;
			armed  <= 1'b0;
		end else begin
			lo_cnt <= ready_busy ? 32'h0 : lo_cnt + 32'h1;
			if ($fell(ready_busy)) begin
				armed <= 1'b1;
			end
		end
	end

	property p_oe_off;
		chip_select_n [*6] |-> !serial_out_oe;
	endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("serial output driven while deselected");
	property p_oe_fall;
		$fell(serial_out_oe) |-> $past(chip_select_n, 3);
	endproperty
	a_oe_fall: assert property (p_oe_fall)
		else $error("output enable dropped inside a frame");
	property p_oe_rise_sel;
		$rose(serial_out_oe) |-> !$past(chip_select_n, 3);
	endproperty
	a_oe_rise_sel: assert property (p_oe_rise_sel)
		else $error("output enable rose without a frame");
	property p_oe_rise_sck;
		$rose(serial_out_oe) |-> $past(serial_clock, 3) || $past(serial_clock, 5);
	endproperty
	a_oe_rise_sck: assert property (p_oe_rise_sck)
		else $error("output enable not tied to a clock rise");
	property p_out_fall;
		serial_out_oe && $past(serial_out_oe) && !chip_select_n
			&& $changed(serial_out)
			|-> !$past(serial_clock, 2) || !$past(serial_clock, 3);
	endproperty
	a_out_fall: assert property (p_out_fall)
		else $error("serial output moved outside a clock low phase");
	property p_busy_len;
		$rose(ready_busy) && armed
			|-> lo_cnt >= BUSY_CYC - 4 && lo_cnt <= BUSY_CYC + 8;
	endproperty
	a_busy_len: assert property (p_busy_len)
		else $error("busy period length wrong");
	property p_busy_launch;
		$fell(ready_busy) |-> chip_select_n;
	endproperty
	a_busy_launch: assert property (p_busy_launch)
		else $error("busy started inside a frame");
	property p_ready_reset;
		$rose(reset_n) |-> ##[1:8] ready_busy;
	endproperty
	a_ready_reset: assert property (p_ready_reset)
		else $error("not ready after reset");
endmodule // sfce_flash_engine_sva

//--- verif/sfce_host_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// Host serial master; pins move only at core clock falls, clock parks low.
module sfce_host_model (
	input  wire logic core_clk,
	input  wire logic serial_out,
	output logic      serial_clock,
	output logic      chip_select_n,
	output logic      serial_in
);
	// Idle state: deselected with the clock standing still.
	initial begin
		serial_clock  = 1'b0;
		chip_select_n = 1'b1;
		serial_in     = 1'b0;
	end

	// Parking the clock low is how a boundary delay is honoured.
	task automatic wait_n(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	task automatic begin_frame();
		wait_n(1);
		chip_select_n = 1'b0;
		wait_n(2);
	endtask

	// The data line is inverted so a stale level is never relied on.
	task automatic end_frame();
		wait_n(1);
		chip_select_n = 1'b1;
		serial_in     = ~serial_in;
		wait_n(6);
	endtask

	// Data set in the low phase, reply taken late in the high phase.
	task automatic xfer(input logic [63:0] d, input int n,
		output logic [63:0] q);
		q = 64'h0;
		for (int i = n - 1; i >= 0; i--) begin
			serial_in = d[i];
			wait_n(4);
			serial_clock = 1'b1;
			wait_n(4);
			q = {q[62:0], serial_out};
			serial_clock = 1'b0;
		end
	endtask
endmodule // sfce_host_model

//--- verif/tb.sv
`timescale 1ns/100ps
`include "sfce_defines.vh"
////////////////////////////////////////////////////////////////////////////
// Self-checking bench; arrays below predict buffer and page contents.
module tb;
	logic        core_clk;
	logic        reset_n;
	wire         serial_clock;
	wire         chip_select_n;
	wire         serial_in;
	wire         serial_out;
	wire         serial_out_oe;
	wire         ready_busy;
	wire         so_pin;
	int          n_mismatch;
	int          n_checks;
	logic [31:0] seed;
	logic [63:0] q;
	logic        exp_comp;
	logic [7:0]  bfm [2][264];
	logic [7:0]  mem [16][264];

	// Core clock at 50 MHz.
	initial core_clk = 1'b0;
	always #10 core_clk = ~core_clk;

	// Short busy times keep the run small; all five are equal on purpose.
	// The array keeps its full page count; only low pages are modelled.
	sfce_flash_engine #(
		.ERASE_PROGRAM_CYC(3000),
		.PROGRAM_CYC      (3000),
		.PAGE_ERASE_CYC   (3000),
		.BLOCK_ERASE_CYC  (3000),
		.XFER_CYC         (3000)
	) dut (
		.core_clk     (core_clk),
		.reset_n      (reset_n),
		.serial_clock (serial_clock),
		.chip_select_n(chip_select_n),
		.serial_in    (serial_in),
		.serial_out   (serial_out),
		.serial_out_oe(serial_out_oe),
		.ready_busy   (ready_busy)
	);

	// A released output line shows the inverse, so a stale level is caught.
	assign so_pin = serial_out_oe ? serial_out : ~serial_out;

	sfce_host_model h (
		.core_clk     (core_clk),
		.serial_out   (so_pin),
		.serial_clock (serial_clock),
		.chip_select_n(chip_select_n),
		.serial_in    (serial_in)
	);

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Opcode and 24-bit field, then nd random filler bits.
	task automatic cmd(input logic [7:0] op, input logic [23:0] a,
		input int nd);
		h.begin_frame();
		h.xfer({32'h0, op, a}, 32, q);
		if (nd > 0) begin
			h.xfer({rnd(), rnd()}, nd, q);
		end
	endtask

	task automatic close();
		h.end_frame();
		check({7'h0, serial_out_oe}, 8'h00);
	endtask

	task automatic rd(input logic [7:0] e);
		h.xfer({32'h0, rnd()}, 8, q);
		check(q[7:0], e);
	endtask

	// Two status copies per frame; the second one is sampled afresh.
	task automatic stat(input logic [7:0] op);
		h.begin_frame();
		h.xfer({56'h0, op}, 8, q);
		repeat (2) rd({1'b1, exp_comp, `SFCE_DENSITY, 3'h0});
		close();
	endtask

	task automatic wr(input int b, input int a, input int n);
		logic [7:0] v;
		cmd(b ? 8'h87 : 8'h84, {15'(rnd()), 9'(a)}, 0);
		for (int i = 0; i < n; i++) begin
			v = 8'(rnd());
			h.xfer({56'h0, v}, 8, q);
			bfm[b][(a + i) % 264] = v;
		end
		close();
	endtask

	task automatic bfrd(input int b, input int a, input int n);
		logic [7:0] op;
		op = (b ? 8'h56 : 8'h54) | (8'(rnd()) & 8'h80);
		cmd(op, {15'(rnd()), 9'(a)}, 8);
		for (int i = 0; i < n; i++) begin
			rd(bfm[b][(a + i) % 264]);
		end
		close();
	endtask

	task automatic pgrd(input int p, input int by, input int n);
		cmd(8'h52 | (8'(rnd()) & 8'h80), {4'h0, 11'(p), 9'(by)}, 32);
		for (int i = 0; i < n; i++) begin
			rd(mem[p][(by + i) % 264]);
		end
		close();
	endtask

	// Array read runs on into the next page at each page end.
	task automatic arrd(input int p, input int by, input int n);
		int idx;
		cmd(8'h68 | (8'(rnd()) & 8'h80), {4'h0, 11'(p), 9'(by)}, 32);
		for (int i = 0; i < n; i++) begin
			idx = p * 264 + by + i;
			rd(mem[idx / 264][idx % 264]);
		end
		close();
	endtask

	// Launch an array operation and update the predicted image.
	task automatic arr(input logic [7:0] op, input int p);
		logic b;
		b = (op == 8'h86) || (op == 8'h55) || (op == 8'h61);
		cmd(op, {4'h0, 11'(p), 9'(rnd())}, 0);
		close();
		exp_comp = (op == 8'h60 || op == 8'h61) ? 1'b0 : exp_comp;
		for (int i = 0; i < 264; i++) begin
			case (op)
			8'h83, 8'h86: mem[p][i] = bfm[b][i];
			8'h88: mem[p][i] = mem[p][i] & bfm[0][i];
			8'h81: mem[p][i] = `SFCE_ERASED;
			8'h55: bfm[1][i] = mem[p][i];
			8'h60, 8'h61: exp_comp = exp_comp | (mem[p][i] != bfm[b][i]);
			8'h50: for (int k = 0; k < 8; k++) begin
				mem[(p & ~7) + k][i] = `SFCE_ERASED;
			end
			default: ;
			endcase
		end
	endtask

	// Clock parked after bit 7; the output must follow ready live.
	task automatic wait_ready();
		int k;
		h.begin_frame();
		h.xfer({56'h0, 8'hD7}, 8, q);
		h.wait_n(6);
		check({7'h0, so_pin}, 8'h00);
		check({7'h0, ready_busy}, 8'h00);
		k = 0;
		while (so_pin !== 1'b1 && k < 4000) begin
			h.wait_n(1);
			k++;
		end
		check({7'h0, so_pin}, 8'h01);
		check({7'h0, ready_busy}, 8'h01);
		if (k >= 4000) begin
			finish_test();
		end
		close();
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence; each array operation completes before the next one.
	initial begin
		seed = 32'h3f02bcc3;
		n_mismatch = 0;
		n_checks = 0;
		exp_comp = 1'b0;
		reset_n = 1'b0;
		repeat (10) @(posedge core_clk);
		@(negedge core_clk);
		reset_n = 1'b1;
		h.wait_n(6);
		stat(8'h57);
		stat(8'hD7);
		wr(0, 0, 264);
		wr(0, 262, 4);
		wr(1, 263, 2);
		bfrd(0, 261, 6);
		bfrd(1, 263, 2);
		arr(8'h83, 2);
		wr(1, 5, 2);
		wait_ready();
		pgrd(2, 260, 6);
		arr(8'h86, 3);
		wait_ready();
		arrd(2, 262, 3);
		arr(8'h83, 9);
		wait_ready();
		arr(8'h50, 8 + int'(rnd() % 8));
		wait_ready();
		pgrd(9, 0, 2);
		pgrd(2, 0, 2);
		arr(8'h81, 5);
		wait_ready();
		pgrd(5, 100, 2);
		arr(8'h88, 5);
		wait_ready();
		pgrd(5, 0, 3);
		arr(8'h60, 2);
		wait_ready();
		stat(8'h57);
		arr(8'h60, 9);
		wait_ready();
		stat(8'hD7);
		arr(8'h55, 2);
		wait_ready();
		bfrd(1, 0, 3);
		arr(8'h61, 2);
		wait_ready();
		stat(8'h57);
		finish_test();
	end
endmodule // tb

bind sfce_flash_engine sfce_flash_engine_sva #(
	.BUSY_CYC(PROGRAM_CYC)
) u_sva (
	.core_clk     (core_clk),
	.reset_n      (reset_n),
	.serial_clock (serial_clock),
	.chip_select_n(chip_select_n),
	.serial_in    (serial_in),
	.serial_out   (serial_out),
	.serial_out_oe(serial_out_oe),
	.ready_busy   (ready_busy)
);
